// ===== src/spmd_pkg.sv
// Shared constants and types of the protection-map table reader and table server
package spmd_pkg;
  // ***********************************************************
  // Table byte locations
  // ***********************************************************
  localparam logic [11:0] SPMD_DESC_LO    = 12'h04c; // Size types one and two
  localparam logic [11:0] SPMD_DESC_HI    = 12'h050; // Size types three and four
  localparam logic [11:0] SPMD_SECT_BASE  = 12'h24c; // First section word
  localparam logic [11:0] SPMD_SECT_STEP  = 12'h004; // One word per section
  // ***********************************************************
  // Size type codes and size exponents
  // ***********************************************************
  localparam logic [7:0]  SPMD_TYPE_4K    = 8'h01;
  localparam logic [7:0]  SPMD_TYPE_8K    = 8'h02;
  localparam logic [7:0]  SPMD_TYPE_32K   = 8'h03;
  localparam logic [7:0]  SPMD_TYPE_64K   = 8'h04;
  localparam logic [7:0]  SPMD_EXP_4K     = 8'h0c; // Log2 of block bytes
  localparam logic [7:0]  SPMD_EXP_8K     = 8'h0d;
  localparam logic [7:0]  SPMD_EXP_32K    = 8'h0f;
  localparam logic [7:0]  SPMD_EXP_64K    = 8'h10;
  // ***********************************************************
  // Section fields: count exponent, start adder, end adder
  // ***********************************************************
  localparam logic [7:0]  SPMD_S1_CNT     = 8'h02; // Four blocks
  localparam logic [7:0]  SPMD_S1_START   = 8'hff; // Minus one
  localparam logic [7:0]  SPMD_S1_END     = 8'h04;
  localparam logic [7:0]  SPMD_S2_CNT     = 8'h00; // One block
  localparam logic [7:0]  SPMD_S2_ADD     = 8'hfd; // Minus three
  localparam logic [7:0]  SPMD_S3_START   = 8'h00; // Bit zero itself
  localparam logic [7:0]  SPMD_S3_END     = 8'hfc; // Minus four
  localparam logic [7:0]  SPMD_S4_CNT     = 8'h00;
  localparam logic [7:0]  SPMD_S4_ADD     = 8'hfe; // Minus two
  localparam logic [7:0]  SPMD_S5_CNT     = 8'h02;
  localparam logic [7:0]  SPMD_S5_START   = 8'h07;
  localparam logic [7:0]  SPMD_S5_END     = 8'h0e;
  // ***********************************************************
  // Density constant and reader registers
  // ***********************************************************
  localparam int          SPMD_M_MIN      = 4;
  localparam int          SPMD_M_MAX      = 8;
  localparam logic [3:0]  SPMD_M_RESET    = 4'h6;
  localparam int          SPMD_NSECT      = 5;
  localparam logic [2:0]  SPMD_NREAD      = 3'h7; // Two descriptor words, five sections
  localparam logic [2:0]  SPMD_REG_CTRL   = 3'h0;
  localparam logic [2:0]  SPMD_REG_DENS   = 3'h1;
  localparam logic [2:0]  SPMD_REG_SEL    = 3'h2;
  localparam logic [2:0]  SPMD_REG_FIRST  = 3'h3;
  localparam logic [2:0]  SPMD_REG_LAST   = 3'h4;
  localparam logic [2:0]  SPMD_REG_BITS   = 3'h5;
  localparam logic [2:0]  SPMD_REG_INFO   = 3'h6;

  typedef enum logic [1:0] {
    SPMD_IDLE = 2'b00,
    SPMD_REQ  = 2'b01,
    SPMD_WAIT = 2'b10,
    SPMD_NEXT = 2'b11
  } spmd_state_t;
endpackage

// ===== src/spmd_if.sv
// Table read link between the table reader and the table server
`timescale 1ns/10ps
`default_nettype none
interface spmd_if;
  logic        req;   // One-cycle read request
  logic [11:0] addr;  // Word-aligned table byte address
  logic        ack;   // One-cycle answer
  logic [31:0] rdata; // Four table bytes, lowest address in bits 7:0
  modport dev (input req, input addr, output ack, output rdata);
  modport host (output req, output addr, input ack, input rdata);
endinterface
`default_nettype wire

// ===== src/spmd_table.sv
// Table server: organisation table words and address-to-protection-bit map
//
// How it works
// - Four size types, descriptors at 4C/4E/50/52
// - 8K type two, 32K three, 64K four
// - Repeated type after another is new section
// - Types two, three: count is two^n
// - Type four: count is two^m minus two
// - m is 4..8 by density, shared
// - Zero start field means bit zero
// - Nonzero field: two^m plus one plus adder
// - Adders are eight-bit two's complement
// - Section bits consecutive, span matches block count; bottom 8K word spans 6 bits where its 4 blocks need 8
// - Layout: 4x8K, 32K, 64K run, 32K, 4x8K
// - Bottom 8K adders FF and 04
// - Lower 32K both adders FD
// - 64K starts bit zero, end adder FC
// - Upper 32K both adders FE
// - Top 8K adders 07 and 0E
// - 8K sections: odd bits read, even write
// - Section fields type,count,start,end in one word
`timescale 1ns/10ps
`default_nettype none
module spmd_table
  import spmd_pkg::*;
#(
  parameter int DENS_M = 6 // Density constant m
) (
  input  wire logic        I_CORE_CLK,  // Core clock
  input  wire logic        I_NRST,      // Asynchronous reset, active low
  spmd_if.dev              LINK,        // Table read link
  input  wire logic [23:0] I_MAP_ADDR,  // Flash byte address to classify
  output var  logic [2:0]  O_MAP_SECT,  // Section index, 7 when outside memory
  output var  logic [9:0]  O_MAP_WBIT,  // Write-lock bit of that block
  output var  logic [9:0]  O_MAP_RBIT,  // Read-lock bit, 8K blocks only
  output var  logic        O_MAP_RDLK   // Block has a read-lock bit
);
  // ***********************************************************
  // Parameter check
  // ***********************************************************
  // Only the five published densities have a defined layout
  if (DENS_M < SPMD_M_MIN || DENS_M > SPMD_M_MAX) begin : g_bad_m
    $error("DENS_M must lie between 4 and 8");
  end

  // ***********************************************************
  // Derived geometry
  // ***********************************************************
  localparam logic [24:0] MEM_TOP  = 25'(1) << (DENS_M + 16); // Bytes in part
  localparam logic [9:0]  POW_M    = 10'(1) << DENS_M;        // Two to the m
  localparam logic [24:0] LOW_8K   = 25'h008000;              // End of bottom 8K run
  localparam logic [24:0] LOW_32K  = 25'h010000;              // End of lower 32K
  localparam logic [24:0] HI_32K   = MEM_TOP - 25'h010000;    // Start of upper 32K
  localparam logic [24:0] HI_8K    = MEM_TOP - 25'h008000;    // Start of top 8K run
  localparam logic [7:0]  CNT_64K  = 8'(DENS_M);              // Count byte carries m

  // ***********************************************************
  // Table word decode
  // ***********************************************************
  // Unlisted locations read as zero so a reader sees no section there
  logic [31:0] word_sel; // Table word at the requested address
  always_comb begin
    unique case (LINK.addr)
      // Size type descriptors, exponent in the low byte of each half
      SPMD_DESC_LO: word_sel = {8'h00, SPMD_EXP_8K, 8'h00, SPMD_EXP_4K};
      SPMD_DESC_HI: word_sel = {8'h00, SPMD_EXP_64K, 8'h00, SPMD_EXP_32K};
      // Bottom four 8K parameter blocks
      SPMD_SECT_BASE:
        word_sel = {SPMD_S1_END, SPMD_S1_START, SPMD_S1_CNT, SPMD_TYPE_8K};
      // Lower single 32K block
      SPMD_SECT_BASE + SPMD_SECT_STEP:
        word_sel = {SPMD_S2_ADD, SPMD_S2_ADD, SPMD_S2_CNT, SPMD_TYPE_32K};
      // Run of 64K blocks; count comes from m on the reader side
      SPMD_SECT_BASE + 12'h008:
        word_sel = {SPMD_S3_END, SPMD_S3_START, CNT_64K, SPMD_TYPE_64K};
      // Upper single 32K block, same type as section two but a new section
      SPMD_SECT_BASE + 12'h00c:
        word_sel = {SPMD_S4_ADD, SPMD_S4_ADD, SPMD_S4_CNT, SPMD_TYPE_32K};
      // Top four 8K parameter blocks
      SPMD_SECT_BASE + 12'h010:
        word_sel = {SPMD_S5_END, SPMD_S5_START, SPMD_S5_CNT, SPMD_TYPE_8K};
      default: word_sel = 32'h00000000;
    endcase
  end

  // ***********************************************************
  // Read answer
  // ***********************************************************
  // Answer one cycle after each request; no back-pressure needed
  logic        ack_q;   // Answer strobe
  logic [31:0] rdata_q; // Answer data
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= LINK.req;
      // Data only moves with a request, so it holds between answers
      if (LINK.req) begin
        rdata_q <= word_sel;
      end
    end
  end
  assign LINK.ack   = ack_q;
  assign LINK.rdata = rdata_q;

  // ***********************************************************
  // Address map decode
  // ***********************************************************
  wire logic [24:0] map_a    = {1'b0, I_MAP_ADDR};      // Widened to compare with top
  wire logic        in_mem   = map_a < MEM_TOP;          // Address exists in this density
  wire logic        in_bot8  = map_a < LOW_8K;           // Bottom 8K run
  wire logic        in_low32 = map_a < LOW_32K;          // Lower 32K block
  wire logic        in_64k   = map_a < HI_32K;           // 64K run
  wire logic        in_hi32  = map_a < HI_8K;            // Upper 32K block
  wire logic [1:0]  bot_idx  = map_a[14:13];             // Block within bottom run
  wire logic [24:0] top_off  = map_a - HI_8K;            // Offset into top run
  wire logic [1:0]  top_idx  = top_off[14:13];           // Block within top run
  wire logic [9:0]  blk_64k  = 10'(map_a[24:16]) - 10'h001; // 64K bit index

  // 8K blocks own a write bit then a read bit; the others one write bit
  logic [2:0] sect_d; // Next section index
  logic [9:0] wbit_d; // Next write-lock bit
  logic       rdlk_d; // Next read-lock presence
  always_comb begin
    sect_d = 3'h7;
    wbit_d = 10'h000;
    rdlk_d = 1'b0;
    if (!in_mem) begin
      // Outside the part: no bit guards it
      sect_d = 3'h7;
    end else if (in_bot8) begin
      sect_d = 3'h0;
      wbit_d = POW_M + {7'h00, bot_idx, 1'b0};
      rdlk_d = 1'b1;
    end else if (in_low32) begin
      sect_d = 3'h1;
      wbit_d = POW_M - 10'h002;
    end else if (in_64k) begin
      sect_d = 3'h2;
      wbit_d = blk_64k;
    end else if (in_hi32) begin
      sect_d = 3'h3;
      wbit_d = POW_M - 10'h001;
    end else begin
      sect_d = 3'h4;
      wbit_d = POW_M + 10'h008 + {7'h00, top_idx, 1'b0};
      rdlk_d = 1'b1;
    end
  end

  // ***********************************************************
  // Map outputs
  // ***********************************************************
  // Registered so the outputs are glitch free; one cycle of latency
  logic [2:0] sect_q; // Section index
  logic [9:0] wbit_q; // Write-lock bit
  logic [9:0] rbit_q; // Read-lock bit
  logic       rdlk_q; // Read-lock present
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sect_q <= 3'h7;
      wbit_q <= 10'h000;
      rbit_q <= 10'h000;
      rdlk_q <= 1'b0;
    end else begin
      sect_q <= sect_d;
      wbit_q <= wbit_d;
      // Odd neighbour of the write bit, zero where none exists
      rbit_q <= rdlk_d ? (wbit_d | 10'h001) : 10'h000;
      rdlk_q <= rdlk_d;
    end
  end
  assign O_MAP_SECT = sect_q;
  assign O_MAP_WBIT = wbit_q;
  assign O_MAP_RBIT = rbit_q;
  assign O_MAP_RDLK = rdlk_q;
endmodule // spmd_table
`default_nettype wire

// ===== src/spmd_reader.sv
// Table reader: fetches the organisation table and decodes each section
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module spmd_reader
  import spmd_pkg::*;
(
  input  wire logic        I_CORE_CLK,          // Core clock
  input  wire logic        I_NRST,              // Asynchronous reset, active low
  spmd_if.host             LINK,                // Table read link
  input  wire logic [2:0]  I_AVS_ADDRESS,       // Word address
  input  wire logic        I_AVS_READ,          // Read strobe
  input  wire logic        I_AVS_WRITE,         // Write strobe
  input  wire logic [31:0] I_AVS_WRITEDATA,     // Write data
  output var  logic [31:0] O_AVS_READDATA,      // Read data
  output var  logic        O_AVS_WAITREQUEST    // Stall
);
  // ***********************************************************
  // Bus slave
  // ***********************************************************
  logic        wait_q;  // Waitrequest, high except in the answer cycle
  logic [31:0] rdat_q;  // Read data
  logic [3:0]  m_q;     // Density constant
  logic [2:0]  sel_q;   // Section shown in the result registers
  logic        busy_q;  // Fetch in progress
  logic        done_q;  // Fetch finished
  logic        err_q;   // Some section was invalid
  wire logic   acc      = (I_AVS_READ | I_AVS_WRITE) & wait_q; // Taken this edge
  wire logic   wr_done  = I_AVS_WRITE & ~wait_q;               // Write completes
  wire logic   start    = wr_done && I_AVS_ADDRESS == SPMD_REG_CTRL
                          && I_AVS_WRITEDATA[0] && !busy_q;    // Ignored while busy
  wire logic   m_ok     = I_AVS_WRITEDATA[3:0] >= 4'(SPMD_M_MIN)
                          && I_AVS_WRITEDATA[3:0] <= 4'(SPMD_M_MAX);

  // Result storage, one entry per section
  logic [24:0] first_q [SPMD_NSECT]; // First byte address
  logic [24:0] last_q  [SPMD_NSECT]; // Last byte address
  logic [9:0]  bs_q    [SPMD_NSECT]; // Start bit
  logic [9:0]  be_q    [SPMD_NSECT]; // End bit
  logic [7:0]  type_q  [SPMD_NSECT]; // Size type
  logic [15:0] cnt_q   [SPMD_NSECT]; // Block count
  logic [2:0]  flag_q  [SPMD_NSECT]; // Valid, span ok, parameter block

  logic [31:0] rd_sel; // Read mux
  always_comb begin
    unique case (I_AVS_ADDRESS)
      SPMD_REG_CTRL:  rd_sel = {29'h0, err_q, done_q, busy_q};
      SPMD_REG_DENS:  rd_sel = {28'h0, m_q};
      SPMD_REG_SEL:   rd_sel = {29'h0, sel_q};
      SPMD_REG_FIRST: rd_sel = {7'h0, first_q[sel_q]};
      SPMD_REG_LAST:  rd_sel = {7'h0, last_q[sel_q]};
      SPMD_REG_BITS:  rd_sel = {flag_q[sel_q], 3'h0, be_q[sel_q], 6'h0, bs_q[sel_q]};
      SPMD_REG_INFO:  rd_sel = {8'h0, type_q[sel_q], cnt_q[sel_q]};
      default:        rd_sel = 32'h00000000; // Unmapped reads zero
    endcase
  end

  // One stall cycle per access; writes land on the completing edge
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      wait_q <= 1'b1;
      rdat_q <= 32'h00000000;
      m_q    <= SPMD_M_RESET;
      sel_q  <= 3'h0;
    end else begin
      wait_q <= ~acc;
      if (acc) begin
        rdat_q <= rd_sel;
      end
      // A density outside 4..8 is refused, the old value stays
      if (wr_done && I_AVS_ADDRESS == SPMD_REG_DENS && m_ok && !busy_q) begin
        m_q <= I_AVS_WRITEDATA[3:0];
      end
      if (wr_done && I_AVS_ADDRESS == SPMD_REG_SEL && I_AVS_WRITEDATA[2:0] < 3'(SPMD_NSECT)) begin
        sel_q <= I_AVS_WRITEDATA[2:0];
      end
    end
  end
  assign O_AVS_WAITREQUEST = wait_q;
  assign O_AVS_READDATA    = rdat_q;

  // ***********************************************************
  // Section decode
  // ***********************************************************
  logic [7:0]  exp_q [4];     // Size exponent per type
  logic [24:0] run_q;         // Next free byte address
  logic [2:0]  idx_q;         // Read index
  wire logic [7:0]  f_type = LINK.rdata[7:0];
  wire logic [7:0]  f_n    = LINK.rdata[15:8];
  wire logic [7:0]  f_s    = LINK.rdata[23:16];   // protect_bit_start_field
  wire logic [7:0]  f_e    = LINK.rdata[31:24];   // protect_bit_end_field
  wire logic        t_ok   = f_type >= SPMD_TYPE_4K && f_type <= SPMD_TYPE_64K;
  wire logic        is64   = f_type == SPMD_TYPE_64K;
  wire logic        is8    = f_type == SPMD_TYPE_8K;
  wire logic [10:0] pow_m  = 11'(1) << m_q;
  wire logic [10:0] base   = pow_m + 11'h001;
  wire logic [10:0] bit_s  = (f_s == 8'h00) ? 11'h000 : base + {{3{f_s[7]}}, f_s};
  wire logic [10:0] bit_e  = (f_e == 8'h00) ? 11'h000 : base + {{3{f_e[7]}}, f_e};
  wire logic        n_ok   = f_n < 8'h10;
  wire logic [15:0] cnt    = is64 ? 16'(pow_m) - 16'h0002
                                  : (n_ok ? 16'(1) << f_n[3:0] : 16'h0000);
  wire logic [10:0] span   = bit_e - bit_s + 11'h001;
  wire logic [16:0] want   = is8 ? {cnt, 1'b0} : {1'b0, cnt};
  wire logic        sp_ok  = {6'h0, span} == want;
  wire logic [10:0] lim    = pow_m + 11'h010;      // Register length
  wire logic        b_ok   = !bit_s[10] && !bit_e[10] && bit_s < lim
                             && bit_e < lim && bit_e >= bit_s;
  wire logic [7:0]  t_exp  = exp_q[f_type[1:0] - 2'h1];
  wire logic [24:0] size   = 25'({9'h0, cnt} << t_exp[4:0]);
  wire logic        sec    = idx_q >= 3'h2;
  wire logic [2:0]  sn     = idx_q - 3'h2;

  // ***********************************************************
  // Fetch sequencer
  // ***********************************************************
  spmd_state_t st_q;  // Sequencer state
  logic        req_q; // Link request
  logic [11:0] adr_q; // Link address
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st_q   <= SPMD_IDLE;
      req_q  <= 1'b0;
      adr_q  <= 12'h000;
      idx_q  <= 3'h0;
      run_q  <= 25'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      req_q <= 1'b0;
      case (st_q)
        SPMD_IDLE: begin
          if (start) begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
            err_q  <= 1'b0;
            idx_q  <= 3'h0;
            run_q  <= 25'h0;
            st_q   <= SPMD_REQ;
          end
        end
        SPMD_REQ: begin
          req_q <= 1'b1;
          adr_q <= (idx_q == 3'h0) ? SPMD_DESC_LO : (idx_q == 3'h1) ? SPMD_DESC_HI
                   : SPMD_SECT_BASE + {7'h0, sn, 2'b00};
          st_q  <= SPMD_WAIT;
        end
        SPMD_WAIT: begin
          if (LINK.ack) begin
            // Each word is its own section, never merged with a neighbour
            if (sec) begin
              run_q <= run_q + size;
              if (!(t_ok && n_ok && b_ok)) begin
                err_q <= 1'b1;
              end
            end
            st_q <= SPMD_NEXT;
          end
        end
        SPMD_NEXT: begin
          idx_q <= idx_q + 3'h1;
          if (idx_q + 3'h1 == SPMD_NREAD) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q   <= SPMD_IDLE;
          end else begin
            st_q <= SPMD_REQ;
          end
        end
        default: st_q <= SPMD_IDLE;
      endcase
    end
  end
  assign LINK.req  = req_q;
  assign LINK.addr = adr_q;

  // Results are written as each answer arrives
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int i = 0; i < 4; i++) begin
        exp_q[i] <= 8'h00;
      end
      for (int i = 0; i < SPMD_NSECT; i++) begin
        first_q[i] <= 25'h0;
        last_q[i]  <= 25'h0;
        bs_q[i]    <= 10'h000;
        be_q[i]    <= 10'h000;
        type_q[i]  <= 8'h00;
        cnt_q[i]   <= 16'h0000;
        flag_q[i]  <= 3'h0;
      end
    end else if (st_q == SPMD_WAIT && LINK.ack) begin
      if (!sec) begin
        exp_q[{idx_q[0], 1'b0}] <= LINK.rdata[7:0];
        exp_q[{idx_q[0], 1'b1}] <= LINK.rdata[23:16];
      end else begin
        first_q[sn] <= run_q;
        last_q[sn]  <= run_q + size - 25'h1;
        bs_q[sn]    <= bit_s[9:0];
        be_q[sn]    <= bit_e[9:0];
        type_q[sn]  <= f_type;
        cnt_q[sn]   <= cnt;
        flag_q[sn]  <= {t_ok && n_ok && b_ok, sp_ok, is8};
      end
    end
  end
endmodule // spmd_reader
`default_nettype wire

// ===== verif/spmd_link_props.sv
// Checker for the table read link between table reader and table server
`timescale 1ns/10ps
`default_nettype none
module spmd_link_props
  import spmd_pkg::*;
(
  input wire logic        I_CORE_CLK, // Core clock
  input wire logic        I_NRST,     // Asynchronous reset, active low
  input wire logic        req,        // Read request pulse
  input wire logic [11:0] addr,       // Table byte address
  input wire logic        ack,        // Answer pulse
  input wire logic [31:0] rdata       // Answer word
);
  // ***********************************************************
  // Link timing and table contents
  // ***********************************************************
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  // A request at one address, answered on the next edge
  sequence ans_s(logic [11:0] a);
    req && addr == a ##1 ack;
  endsequence
  ack_timing_a: assert property (req |=> ack) else $error("answer late");
  ack_cause_a: assert property (ack |-> $past(req)) else $error("stray answer");
  req_spacing_a: assert property (req |=> !req ##1 !req) else $error("requests too close");
  addr_hold_a: assert property (req |=> $stable(addr) && addr[1:0] == 2'h0)
    else $error("address moved or unaligned");
  rdata_hold_a: assert property (!ack |-> $stable(rdata)) else $error("word changed");
  desc_lo_a: assert property (ans_s(SPMD_DESC_LO) |->
    rdata[7:0] == SPMD_EXP_4K && rdata[23:16] == SPMD_EXP_8K) else $error("bad low descriptor");
  desc_hi_a: assert property (ans_s(SPMD_DESC_HI) |->
    rdata[7:0] == SPMD_EXP_32K && rdata[23:16] == SPMD_EXP_64K) else $error("bad high descriptor");
  bottom_word_a: assert property (ans_s(SPMD_SECT_BASE) |->
    rdata == {SPMD_S1_END, SPMD_S1_START, SPMD_S1_CNT, SPMD_TYPE_8K}) else $error("bad bottom word");
  lower_word_a: assert property (ans_s(SPMD_SECT_BASE + 12'h004) |->
    rdata == {SPMD_S2_ADD, SPMD_S2_ADD, SPMD_S2_CNT, SPMD_TYPE_32K}) else $error("bad lower word");
  run_word_a: assert property (ans_s(SPMD_SECT_BASE + 12'h008) |->
    rdata[31:16] == {SPMD_S3_END, SPMD_S3_START} && rdata[7:0] == SPMD_TYPE_64K)
    else $error("bad run word");
  upper_word_a: assert property (ans_s(SPMD_SECT_BASE + 12'h00c) |->
    rdata == {SPMD_S4_ADD, SPMD_S4_ADD, SPMD_S4_CNT, SPMD_TYPE_32K}) else $error("bad upper word");
  top_word_a: assert property (ans_s(SPMD_SECT_BASE + 12'h010) |->
    rdata == {SPMD_S5_END, SPMD_S5_START, SPMD_S5_CNT, SPMD_TYPE_8K}) else $error("bad top word");
endmodule // spmd_link_props
`default_nettype wire

// ===== verif/spmd_test.sv
// Testbench joining table reader and table server over the table link
`timescale 1ns/10ps
`default_nettype none
module spmd_test;
  import spmd_pkg::*;
  // ***********************************************************
  // Signals and expected section fields
  // ***********************************************************
  localparam int DM = 6;        // Table server density
  localparam int B  = 1 << DM;  // Write bit of the first bottom 8K block, two^m
  localparam logic [7:0] SF [5] = '{SPMD_S1_START, SPMD_S2_ADD, SPMD_S3_START, SPMD_S4_ADD,
                                    SPMD_S5_START};
  localparam logic [7:0] EF [5] = '{SPMD_S1_END, SPMD_S2_ADD, SPMD_S3_END, SPMD_S4_ADD, SPMD_S5_END};
  localparam logic [7:0] CN [5] = '{SPMD_S1_CNT, SPMD_S2_CNT, 8'h00, SPMD_S4_CNT, SPMD_S5_CNT};
  localparam logic [7:0] TY [5] = '{SPMD_TYPE_8K, SPMD_TYPE_32K, SPMD_TYPE_64K, SPMD_TYPE_32K,
                                    SPMD_TYPE_8K};
  localparam int         SZ [5] = '{32'h2000, 32'h8000, 32'h10000, 32'h8000, 32'h2000};
  logic        core_clk, nrst, av_rd, av_wr, av_wait, map_rdlk;
  logic [2:0]  av_addr, map_sect;
  logic [31:0] av_wdata, av_rdata;
  logic [23:0] map_addr;
  logic [9:0]  map_wbit, map_rbit;
  int          error_cnt = 0, checks_done = 0, cyc = 0;
  spmd_if link ();
  spmd_table #(.DENS_M(DM)) i_spmd_table (.I_CORE_CLK(core_clk), .I_NRST(nrst), .LINK(link),
    .I_MAP_ADDR(map_addr), .O_MAP_SECT(map_sect), .O_MAP_WBIT(map_wbit),
    .O_MAP_RBIT(map_rbit), .O_MAP_RDLK(map_rdlk));
  spmd_reader i_spmd_reader (.I_CORE_CLK(core_clk), .I_NRST(nrst), .LINK(link),
    .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr),
    .I_AVS_WRITEDATA(av_wdata), .O_AVS_READDATA(av_rdata), .O_AVS_WAITREQUEST(av_wait));
  spmd_link_props i_spmd_link_props (.I_CORE_CLK(core_clk), .I_NRST(nrst), .req(link.req),
    .addr(link.addr), .ack(link.ack), .rdata(link.rdata));
  always #4 core_clk = ~core_clk;
  // Hang guard: the whole run needs several hundred cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ***********************************************************
  // Tasks
  // ***********************************************************
  task automatic end_sim;
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t register read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_map(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t map output %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon access: hold until waitrequest is seen low at a rising edge
  task automatic av_xfer(input logic w, input logic [2:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge core_clk);
    av_addr <= a; av_wdata <= d; av_wr <= w; av_rd <= !w;
    // Waitrequest and read data are taken as they stood at the rising edge
    do @(posedge core_clk); while (av_wait !== 1'h0);
    q = av_rdata;
    av_wr <= 1'h0; av_rd <= 1'h0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    av_xfer(1'h1, a, d, q);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [31:0] e);
    logic [31:0] q;
    av_xfer(1'h0, a, 32'h0, q);
    chk_reg(q, e);
  endtask
  // Map lookup: outputs follow the address one edge later
  task automatic map_chk(input logic [23:0] a, input logic [23:0] e);
    @(posedge core_clk);
    map_addr <= a;
    @(posedge core_clk);
    @(negedge core_clk);
    chk_map({map_sect, map_wbit, map_rbit, map_rdlk}, e);
  endtask
  // Zero field means bit zero, else sign-extended adder on two^m plus one
  function automatic logic [9:0] bitpos(input int m, input logic [7:0] f);
    return (f == 8'h00) ? 10'h000 : 10'((1 << m) + 1 + int'($signed(f)));
  endfunction
  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    logic [31:0] q;
    logic [24:0] first;
    logic [9:0]  st, en;
    int          cnt;
    core_clk = 1'h0; nrst = 1'h0; av_rd = 1'h0; av_wr = 1'h0;
    av_addr = 3'h0; av_wdata = 32'h0; map_addr = 24'h0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'h1;
    rdc(SPMD_REG_DENS, 32'(SPMD_M_RESET));
    rdc(SPMD_REG_CTRL, 32'h0);
    rdc(3'h7, 32'h0);
    wr(SPMD_REG_DENS, 32'h9);
    wr(SPMD_REG_DENS, 32'h3);
    rdc(SPMD_REG_DENS, 32'(SPMD_M_RESET));
    wr(SPMD_REG_SEL, 32'h5);
    rdc(SPMD_REG_SEL, 32'h0);
    for (int m = SPMD_M_MIN; m <= SPMD_M_MAX; m++) begin
      wr(SPMD_REG_DENS, 32'(m));
      wr(SPMD_REG_CTRL, 32'h1);
      wr(SPMD_REG_DENS, (m == 4) ? 32'h8 : 32'h4); // Ignored while fetching
      rdc(SPMD_REG_CTRL, 32'h1);
      do av_xfer(1'h0, SPMD_REG_CTRL, 32'h0, q); while (q[0] !== 1'h0);
      chk_reg(q, 32'h2);
      rdc(SPMD_REG_DENS, 32'(m));
      first = 25'h0;
      for (int s = 0; s < SPMD_NSECT; s++) begin
        cnt = (TY[s] == SPMD_TYPE_64K) ? (1 << m) - 2 : 1 << CN[s];
        st = bitpos(m, SF[s]);
        en = bitpos(m, EF[s]);
        wr(SPMD_REG_SEL, 32'(s));
        rdc(SPMD_REG_INFO, {8'h00, TY[s], 16'(cnt)});
        rdc(SPMD_REG_FIRST, 32'(first));
        first = first + 25'(cnt * SZ[s]);
        rdc(SPMD_REG_LAST, 32'(first - 25'h1));
        rdc(SPMD_REG_BITS, {1'h1, 32'(en - st + 1) == ((TY[s] == SPMD_TYPE_8K) ? 2 * cnt : cnt),
          TY[s] == SPMD_TYPE_8K, 3'h0, en, 6'h00, st});
      end
    end
    map_chk(24'h000000, {3'h0, 10'(B), 10'(B + 1), 1'h1});
    map_chk(24'h006000, {3'h0, 10'(B + 6), 10'(B + 7), 1'h1});
    map_chk(24'h008000, {3'h1, 10'(B - 2), 10'h000, 1'h0});
    map_chk(24'h010000, {3'h2, 10'h000, 10'h000, 1'h0});
    map_chk(24'h3e0000, {3'h2, 10'(B - 3), 10'h000, 1'h0});
    map_chk(24'h3f0000, {3'h3, 10'(B - 1), 10'h000, 1'h0});
    map_chk(24'h3fe000, {3'h4, 10'(B + 14), 10'(B + 15), 1'h1});
    map_chk(24'h400000, {3'h7, 10'h000, 10'h000, 1'h0});
    end_sim();
  end
endmodule // spmd_test
`default_nettype wire
